// file: hw/ppf_consts.vh
// Timing, mode and buffer constants for the parallel port handshake engine
`ifndef PPF_CONSTS_VH
`define PPF_CONSTS_VH

// Clock period in ns
`define PPF_CLK_NS          40

// Minimum times round up to whole cycles, maximum times round down
`define PPF_CEIL(ns)        (((ns) + `PPF_CLK_NS - 1) / `PPF_CLK_NS)
`define PPF_FLOOR(ns)       ((ns) / `PPF_CLK_NS)

// Compatibility FIFO mode times in ns
`define PPF_T_SETUP_NS      600
`define PPF_T_WIDTH_NS      600
`define PPF_T_HOLD_NS       450
`define PPF_T_BUSY_RESP_NS  500
`define PPF_T_GAP_NS        680
`define PPF_T_BUSY_HOLD_NS  80

// ECP forward and reverse turnaround minimum in ns
`define PPF_T_ECP_MIN_NS    80

// Input stability filter minimum in ns
`define PPF_T_FILT_NS       75

// Operating modes
`define PPF_MODE_OFF        2'h0
`define PPF_MODE_COMPAT     2'h1
`define PPF_MODE_ECP_FWD    2'h2
`define PPF_MODE_ECP_REV    2'h3

// Transmit buffer shape: command flag plus one byte
`define PPF_TX_WIDTH        9
`define PPF_TX_DEPTH        8
`define PPF_TX_AW           3

// Pin levels after reset
`define PPF_STROBE_IDLE     1'b1
`define PPF_ACK_IDLE        1'b1
`define PPF_DATA_RESET      8'h00

`endif

// file: hw/ppf_fifo.v
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "ppf_consts.vh"

module ppf_fifo #(
	parameter WIDTH = `PPF_TX_WIDTH,
	parameter DEPTH = `PPF_TX_DEPTH,
	parameter AW    = `PPF_TX_AW
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             rst_i,
	// Fill side
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	// Drain side
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;

	localparam integer  DEPTH_I    = DEPTH;
	localparam integer  LAST_I     = DEPTH - 1;
	localparam [AW:0]   FULL_COUNT = DEPTH_I[AW:0];
	localparam [AW-1:0] LAST_PTR   = LAST_I[AW-1:0];
	localparam [AW-1:0] PTR_ONE    = 1;
	localparam [AW:0]   CNT_ONE    = 1;

	wire push = in_valid_i && in_ready_o;
	wire pop  = out_valid_o && out_ready_i;

	assign in_ready_o  = (count_reg != FULL_COUNT);
	assign out_valid_o = (count_reg != {(AW+1){1'b0}});
	assign out_data_o  = mem_reg[rd_ptr_reg];

	always @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? {AW{1'b0}} : wr_ptr_reg + PTR_ONE;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? {AW{1'b0}} : rd_ptr_reg + PTR_ONE;
			end
			if (push && !pop) begin
				count_reg <= count_reg + CNT_ONE;
			end else if (pop && !push) begin
				count_reg <= count_reg - CNT_ONE;
			end
		end
	end

endmodule // ppf_fifo

// file: hw/ppf_filter.v
// Stability filter for a cable input: a new level passes once it has held
`timescale 1ns/1ps
`include "ppf_consts.vh"

module ppf_filter #(
	parameter INIT = 1'b0
) (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// Raw and filtered level
	input  wire raw_i,
	output wire level_o
);

	localparam integer N_FILT = `PPF_CEIL(`PPF_T_FILT_NS);
	localparam [1:0]   C_FILT = N_FILT[1:0];
	localparam [1:0] C_ONE  = 2'h1;

	reg       level_reg;
	reg [1:0] cnt_reg;

	assign level_o = level_reg;

	// Any bounce back to the old level restarts the wait, which rejects cable ringing
	always @(posedge clk_i) begin
		if (rst_i) begin
			level_reg <= INIT;
			cnt_reg   <= 2'h0;
		end else if (raw_i == level_reg) begin
			cnt_reg <= 2'h0;
		end else if (cnt_reg == C_FILT - C_ONE) begin
			level_reg <= raw_i;
			cnt_reg   <= 2'h0;
		end else begin
			cnt_reg <= cnt_reg + C_ONE;
		end
	end

endmodule // ppf_filter

// file: hw/ppf_handshake.v
// Parallel port handshake engine: compatibility FIFO, ECP forward and ECP reverse
`timescale 1ns/1ps
`include "ppf_consts.vh"

// Summary of operation
// - Compatibility mode paces on busy, ignores acknowledge
// - Data valid 600 ns before strobe
// - Strobe low at least 600 ns
// - Hold data past busy low and 450 ns
// - Last byte stays driven when nothing pending
// - Wait 680 ns after busy low
// - Data stays 80 ns after busy low
// - ECP indicator and data just before strobe
// - ECP data changes 80-180 ns after busy low
// - Forward maximum only while data waits
// - ECP next strobe 80-200 ns after busy low
// - ECP strobe rises 80-180 ns after busy
// - Busy change needs stable filter time
// - Acknowledge rises 80-200 ns after clock low
// - Stall acknowledge low when full or terminal
// - Acknowledge falls 80-200 ns after clock high
// - Clock change needs stable filter time
// - Forward byte is the interlocked five-step sequence
module ppf_handshake (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Mode select and status
	input  wire [1:0] mode_i,
	output wire       active_o,
	output wire       stall_o,
	output wire       busy_late_o,
	// Transmit stream from the system
	input  wire [7:0] tx_data_i,
	input  wire       tx_cmd_i,
	input  wire       tx_valid_i,
	output wire       tx_ready_o,
	// Receive stream to the system
	output wire [7:0] rx_data_o,
	output wire       rx_valid_o,
	input  wire       rx_ready_i,
	input  wire       tc_i,
	// Cable pins
	output wire       host_strobe_n_o,
	output wire       host_ack_n_o,
	output wire [7:0] port_data_o,
	output wire       port_data_oe_o,
	input  wire [7:0] port_data_i,
	input  wire       periph_busy_i,
	input  wire       periph_clk_n_i
);

	// Cycle counts from the nanosecond limits, cut to counter width on purpose
	localparam integer N_SETUP = `PPF_CEIL(`PPF_T_SETUP_NS);
	localparam integer N_WIDTH = `PPF_CEIL(`PPF_T_WIDTH_NS);
	localparam integer N_HOLD  = `PPF_CEIL(`PPF_T_HOLD_NS);
	localparam integer N_RESP  = `PPF_FLOOR(`PPF_T_BUSY_RESP_NS);
	localparam integer N_GAP   = `PPF_CEIL(`PPF_T_GAP_NS);
	localparam integer N_BHOLD = `PPF_CEIL(`PPF_T_BUSY_HOLD_NS);
	localparam integer N_EMIN  = `PPF_CEIL(`PPF_T_ECP_MIN_NS);
	localparam [4:0] C_SETUP = N_SETUP[4:0];
	localparam [4:0] C_WIDTH = N_WIDTH[4:0];
	localparam [4:0] C_HOLD  = N_HOLD[4:0];
	localparam [4:0] C_RESP  = N_RESP[4:0];
	localparam [4:0] C_GAP   = N_GAP[4:0];
	localparam [4:0] C_BHOLD = N_BHOLD[4:0];
	localparam [4:0] C_EMIN  = N_EMIN[4:0];
	localparam [4:0] C_ONE   = 5'h01;
	localparam [4:0] C_SAT   = 5'h1F;

	// States
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_SETUP = 3'h1;
	localparam [2:0] S_STRB  = 3'h2;
	localparam [2:0] S_HOLD  = 3'h3;
	localparam [2:0] S_WLO   = 3'h4;
	localparam [2:0] S_RACK  = 3'h5;

	// Idle level of the acknowledge pin in each mode
	function ack_idle;
		input [1:0] mode;
		input       last_ack;
		begin
			case (mode)
				`PPF_MODE_ECP_FWD: ack_idle = last_ack;
				`PPF_MODE_ECP_REV: ack_idle = 1'b0;
				default:           ack_idle = `PPF_ACK_IDLE;
			endcase
		end
	endfunction

	// Saturating increment keeps long waits from wrapping into a false match
	function [4:0] sat_inc;
		input [4:0] v;
		begin
			sat_inc = (v == C_SAT) ? v : v + C_ONE;
		end
	endfunction

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [4:0] cnt_reg;
	reg [4:0] cnt_next;
	reg [4:0] busy_lo_reg;
	reg [1:0] mode_reg;
	reg       strobe_n_reg;
	reg       strobe_n_next;
	reg       ack_n_reg;
	reg       ack_n_next;
	reg [7:0] data_reg;
	reg [7:0] data_next;
	reg [7:0] rx_data_reg;
	reg       rx_valid_reg;
	reg       rx_take;
	reg       tx_pop;
	reg       busy_late_reg;
	reg       busy_late_next;

	wire       busy_f;
	wire       pclk_n_f;
	wire [8:0] fifo_out;
	wire       fifo_valid;
	wire       mode_change = (mode_i != mode_reg);
	wire       rx_room     = !rx_valid_reg || rx_ready_i;
	wire       gap_ok      = (busy_lo_reg >= C_GAP) && (busy_lo_reg >= C_BHOLD);
	wire       late_evt    = (mode_reg == `PPF_MODE_COMPAT) && (state_reg == S_STRB) &&
	                         !busy_f && (cnt_reg == C_RESP);

	ppf_fifo #(
		.WIDTH (`PPF_TX_WIDTH),
		.DEPTH (`PPF_TX_DEPTH),
		.AW    (`PPF_TX_AW)
	) u_tx_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_data_i   ({tx_cmd_i, tx_data_i}),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (tx_ready_o),
		.out_data_o  (fifo_out),
		.out_valid_o (fifo_valid),
		.out_ready_i (tx_pop)
	);

	ppf_filter #(
		.INIT (1'b0)
	) u_busy_filt (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.raw_i   (periph_busy_i),
		.level_o (busy_f)
	);

	ppf_filter #(
		.INIT (1'b1)
	) u_pclk_filt (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.raw_i   (periph_clk_n_i),
		.level_o (pclk_n_f)
	);

	assign host_strobe_n_o = strobe_n_reg;
	assign host_ack_n_o    = ack_n_reg;
	assign port_data_o     = data_reg;
	assign port_data_oe_o  = (mode_reg != `PPF_MODE_ECP_REV);
	assign rx_data_o       = rx_data_reg;
	assign rx_valid_o      = rx_valid_reg;
	assign active_o        = (state_reg != S_IDLE);
	assign busy_late_o     = busy_late_reg;
	assign stall_o         = (mode_reg == `PPF_MODE_ECP_REV) && (state_reg == S_IDLE) &&
	                         !pclk_n_f && (!rx_room || tc_i);

	// Time since the filtered busy line last went low
	always @(posedge clk_i) begin
		if (rst_i || busy_f) begin
			busy_lo_reg <= 5'h00;
		end else begin
			busy_lo_reg <= sat_inc(busy_lo_reg);
		end
	end

	always @* begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		strobe_n_next  = strobe_n_reg;
		ack_n_next     = ack_n_reg;
		data_next      = data_reg;
		busy_late_next = busy_late_reg;
		tx_pop         = 1'b0;
		rx_take        = 1'b0;
		if (mode_change) begin
			state_next     = S_IDLE;
			cnt_next       = 5'h00;
			strobe_n_next  = `PPF_STROBE_IDLE;
			ack_n_next     = ack_idle(mode_i, ack_n_reg);
			// A late event in the same cycle wins over the clear
			busy_late_next = late_evt;
		end else begin
			case (mode_reg)
				`PPF_MODE_COMPAT: begin
					case (state_reg)
						S_IDLE: begin
							// Without a pending byte the old one simply stays on the pins
							if (fifo_valid && gap_ok) begin
								tx_pop     = 1'b1;
								data_next  = fifo_out[7:0];
								cnt_next   = 5'h00;
								state_next = S_SETUP;
							end
						end
						S_SETUP: begin
							cnt_next = sat_inc(cnt_reg);
							if (cnt_reg >= C_SETUP - C_ONE) begin
								strobe_n_next = 1'b0;
								cnt_next      = 5'h00;
								state_next    = S_STRB;
							end
						end
						S_STRB: begin
							cnt_next = sat_inc(cnt_reg);
							// Flag a peripheral that misses its busy response window
							if (late_evt) begin
								busy_late_next = 1'b1;
							end
							if (cnt_reg >= C_WIDTH - C_ONE) begin
								strobe_n_next = 1'b1;
								cnt_next      = 5'h00;
								state_next    = S_HOLD;
							end
						end
						S_HOLD: begin
							cnt_next = sat_inc(cnt_reg);
							if (cnt_reg >= C_HOLD - C_ONE && !busy_f) begin
								state_next = S_IDLE;
							end
						end
						default: begin
							state_next    = S_IDLE;
							strobe_n_next = `PPF_STROBE_IDLE;
						end
					endcase
				end
				`PPF_MODE_ECP_FWD: begin
					case (state_reg)
						S_IDLE: begin
							// An empty FIFO may idle here without any limit
							if (fifo_valid && !busy_f) begin
								tx_pop     = 1'b1;
								data_next  = fifo_out[7:0];
								ack_n_next = !fifo_out[8];
								state_next = S_SETUP;
							end
						end
						S_SETUP: begin
							// One cycle of setup sits inside the short setup window
							strobe_n_next = 1'b0;
							cnt_next      = 5'h00;
							state_next    = S_STRB;
						end
						S_STRB: begin
							cnt_next = busy_f ? sat_inc(cnt_reg) : 5'h00;
							if (busy_f && cnt_reg >= C_EMIN - C_ONE) begin
								strobe_n_next = 1'b1;
								cnt_next      = 5'h00;
								state_next    = S_WLO;
							end
						end
						S_WLO: begin
							cnt_next = busy_f ? 5'h00 : sat_inc(cnt_reg);
							if (!busy_f && cnt_reg >= C_EMIN - C_ONE) begin
								cnt_next = 5'h00;
								if (fifo_valid) begin
									tx_pop     = 1'b1;
									data_next  = fifo_out[7:0];
									ack_n_next = !fifo_out[8];
									state_next = S_SETUP;
								end else begin
									state_next = S_IDLE;
								end
							end
						end
						default: begin
							state_next    = S_IDLE;
							strobe_n_next = `PPF_STROBE_IDLE;
						end
					endcase
				end
				`PPF_MODE_ECP_REV: begin
					case (state_reg)
						S_IDLE: begin
							cnt_next = pclk_n_f ? 5'h00 : sat_inc(cnt_reg);
							// Full receive side or terminal count holds acknowledge low
							if (!pclk_n_f && cnt_reg >= C_EMIN - C_ONE &&
							    rx_room && !tc_i) begin
								rx_take    = 1'b1;
								ack_n_next = 1'b1;
								cnt_next   = 5'h00;
								state_next = S_RACK;
							end
						end
						S_RACK: begin
							cnt_next = pclk_n_f ? sat_inc(cnt_reg) : 5'h00;
							if (pclk_n_f && cnt_reg >= C_EMIN - C_ONE) begin
								ack_n_next = 1'b0;
								cnt_next   = 5'h00;
								state_next = S_IDLE;
							end
						end
						default: begin
							state_next = S_IDLE;
							ack_n_next = 1'b0;
						end
					endcase
				end
				default: begin
					state_next    = S_IDLE;
					cnt_next      = 5'h00;
					strobe_n_next = `PPF_STROBE_IDLE;
				end
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg     <= S_IDLE;
			cnt_reg       <= 5'h00;
			mode_reg      <= `PPF_MODE_OFF;
			strobe_n_reg  <= `PPF_STROBE_IDLE;
			ack_n_reg     <= `PPF_ACK_IDLE;
			data_reg      <= `PPF_DATA_RESET;
			busy_late_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			mode_reg      <= mode_i;
			strobe_n_reg  <= strobe_n_next;
			ack_n_reg     <= ack_n_next;
			data_reg      <= data_next;
			busy_late_reg <= busy_late_next;
		end
	end

	// Receive holding word; a new capture is only allowed once this slot frees
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_valid_reg <= 1'b0;
			rx_data_reg  <= `PPF_DATA_RESET;
		end else if (rx_take) begin
			rx_valid_reg <= 1'b1;
			rx_data_reg  <= port_data_i;
		end else if (rx_ready_i) begin
			rx_valid_reg <= 1'b0;
		end
	end

endmodule // ppf_handshake

// file: verif/ppf_handshake_assertions.sv
// Handshake timing checker for the parallel port engine
`timescale 1ns/1ps

module ppf_chk (
	// Clock and reset
	input wire       clk_i,
	input wire       rst_i,
	// Stream side
	input wire [1:0] mode_i,
	input wire       tx_valid_i,
	input wire       tx_ready_o,
	input wire       rx_valid_o,
	input wire       tc_i,
	// Cable pins
	input wire       host_strobe_n_o,
	input wire       host_ack_n_o,
	input wire [7:0] port_data_o,
	input wire       periph_busy_i,
	input wire       periph_clk_n_i
);
	reg [7:0] last_reg;
	reg [7:0] dcnt_reg;
	reg [7:0] lcnt_reg;
	reg [7:0] hcnt_reg;
	reg [7:0] bcnt_reg;
	reg [3:0] pend_reg;
	wire      m1 = mode_i == 2'h1;
	wire      m2 = mode_i == 2'h2;
	wire      m3 = mode_i == 2'h3;
	function automatic [7:0] sat(input [7:0] c);
		sat = (c == 8'hff) ? c : c + 8'h01;
	endfunction
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Saturating, so a long idle never wraps into a false short count
	always @(posedge clk_i) begin
		last_reg <= rst_i ? 8'h00 : port_data_o;
		dcnt_reg <= (rst_i || port_data_o != last_reg) ? 8'h01 : sat(dcnt_reg);
		lcnt_reg <= (rst_i || host_strobe_n_o) ? 8'h00 : sat(lcnt_reg);
		hcnt_reg <= (rst_i || !host_strobe_n_o) ? 8'h00 : sat(hcnt_reg);
		bcnt_reg <= (rst_i || periph_busy_i) ? 8'h00 : sat(bcnt_reg);
		// Words pushed in forward ECP that have not yet been strobed out
		pend_reg <= (rst_i || !m2) ? 4'h0 : pend_reg + {3'h0, tx_valid_i & tx_ready_o}
			- {3'h0, $fell(host_strobe_n_o)};
	end
	compat_setup_a: assert property (m1 && $fell(host_strobe_n_o) |-> dcnt_reg >= 8'h0f)
		else $error("data setup before strobe too short");
	compat_width_a: assert property (m1 && $rose(host_strobe_n_o) |-> lcnt_reg >= 8'h0f)
		else $error("strobe pulse too short");
	compat_gap_a: assert property (m1 && $fell(host_strobe_n_o) |-> bcnt_reg >= 8'h11)
		else $error("strobe too soon after busy low");
	compat_hold_a: assert property (m1 && $past(mode_i) == 2'h1 && $changed(port_data_o)
		|-> hcnt_reg >= 8'h0c && bcnt_reg >= 8'h02) else $error("data hold too short");
	ecp_setup_a: assert property (m2 && $fell(host_strobe_n_o) |-> dcnt_reg == 8'h01)
		else $error("forward data not set one cycle before strobe");
	ecp_change_a: assert property (m2 && $fell(periph_busy_i) && pend_reg != 4'h0
		|-> ##[2:4] $changed(port_data_o)) else $error("forward data change late");
	ecp_next_a: assert property (m2 && $fell(periph_busy_i) && pend_reg != 4'h0
		|-> ##[2:5] $fell(host_strobe_n_o)) else $error("next strobe outside window");
	ecp_rise_a: assert property (m2 && $rose(periph_busy_i) |-> ##[2:4] $rose(host_strobe_n_o))
		else $error("strobe release outside window");
	rev_ack_a: assert property (m3 && $fell(periph_clk_n_i) && !tc_i && !rx_valid_o
		|-> ##[2:5] $rose(host_ack_n_o)) else $error("reverse ack rise outside window");
	rev_stall_a: assert property (m3 && tc_i && !host_ack_n_o |=> !host_ack_n_o)
		else $error("ack rose during terminal count");
	rev_release_a: assert property (m3 && $rose(periph_clk_n_i) |-> ##[2:5] $fell(host_ack_n_o))
		else $error("reverse ack fall outside window");
	cover property (m1 && $fell(host_strobe_n_o));
	cover property (m2 && $fell(periph_busy_i) && pend_reg != 4'h0);
	cover property (m3 && tc_i && !periph_clk_n_i);
endmodule // ppf_chk

bind ppf_handshake ppf_chk i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .tx_valid_i(tx_valid_i),
	.tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .tc_i(tc_i),
	.host_strobe_n_o(host_strobe_n_o), .host_ack_n_o(host_ack_n_o),
	.port_data_o(port_data_o), .periph_busy_i(periph_busy_i), .periph_clk_n_i(periph_clk_n_i)
);

// file: verif/ppf_periph.sv
// Behavioural cable peripheral: busy answers and reverse byte sender
`timescale 1ns/1ps

module ppf_periph (
	// Clock
	input  wire        clk_i,
	// Host lines
	input  wire        host_strobe_n_i,
	input  wire        host_ack_n_i,
	// Pacing and peripheral drive
	input  wire  [2:0] dly_i,
	output logic       periph_busy_o,
	output logic       periph_clk_n_o,
	output logic [7:0] drv_data_o
);
	initial begin
		periph_busy_o = 1'b0;
		periph_clk_n_o = 1'b1;
		drv_data_o = 8'h00;
	end
	// Seven cycles at most keeps busy well inside the host's lateness limit
	always begin
		@(posedge clk_i);
		if (host_strobe_n_i === 1'b0) begin
			repeat (dly_i) @(posedge clk_i);
			periph_busy_o <= 1'b1;
			while (host_strobe_n_i !== 1'b1) @(posedge clk_i);
			repeat (dly_i) @(posedge clk_i);
			periph_busy_o <= 1'b0;
		end
	end
	task automatic wait_ack(input logic v);
		int n;
		n = 0;
		while (host_ack_n_i !== v && n < 500) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic send(input logic [7:0] d);
		wait_ack(1'b0);
		drv_data_o <= d;
		@(posedge clk_i);
		periph_clk_n_o <= 1'b0;
		wait_ack(1'b1);
		repeat (dly_i) @(posedge clk_i);
		periph_clk_n_o <= 1'b1;
		wait_ack(1'b0);
		// Released data shows a changed pattern, never the old byte
		drv_data_o <= ~d;
	endtask
endmodule // ppf_periph

// file: verif/tb_top.sv
// Self-checking bench for the parallel port handshake engine
`timescale 1ns/1ps

module tb_top;
	logic       clk_i;
	logic       rst_i;
	logic [1:0] mode_i;
	logic [7:0] tx_data_i;
	logic       tx_cmd_i;
	logic       tx_valid_i;
	logic       rx_ready_i = 1'b1;
	logic       tc_i;
	logic       rnd_rdy;
	logic [2:0] dly = 3'h0;
	logic [7:0] b;
	logic       strobe_prev = 1'b1;
	logic [8:0] expf[$];
	logic [7:0] expr[$];
	integer     seed;
	integer     bad_count;
	integer     num_checks;
	integer     cyc = 0;
	wire        active_o;
	wire        stall_o;
	wire        busy_late_o;
	wire        tx_ready_o;
	wire        rx_valid_o;
	wire [7:0]  rx_data_o;
	wire        host_strobe_n_o;
	wire        host_ack_n_o;
	wire [7:0]  port_data_o;
	wire        port_data_oe_o;
	wire        busy;
	wire        pclk_n;
	wire [7:0]  drv_data;
	wire [7:0]  port_data_w = port_data_oe_o ? port_data_o : drv_data;

	ppf_handshake i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .active_o(active_o),
		.stall_o(stall_o), .busy_late_o(busy_late_o), .tx_data_i(tx_data_i),
		.tx_cmd_i(tx_cmd_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
		.rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
		.tc_i(tc_i), .host_strobe_n_o(host_strobe_n_o), .host_ack_n_o(host_ack_n_o),
		.port_data_o(port_data_o), .port_data_oe_o(port_data_oe_o),
		.port_data_i(port_data_w), .periph_busy_i(busy), .periph_clk_n_i(pclk_n)
	);
	ppf_periph i_per (
		.clk_i(clk_i), .host_strobe_n_i(host_strobe_n_o), .host_ack_n_i(host_ack_n_o),
		.dly_i(dly), .periph_busy_o(busy), .periph_clk_n_o(pclk_n), .drv_data_o(drv_data)
	);

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [8:0] e, input logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	// Called at a falling edge; valid stays up so back-to-back pushes need no gap
	task automatic push(input logic c, input logic [7:0] d);
		tx_cmd_i = c;
		tx_data_i = d;
		tx_valid_i = 1'b1;
		expf.push_back({(mode_i == 2'h2) ? ~c : 1'b1, d});
		while (tx_ready_o !== 1'b1) @(negedge clk_i);
		@(negedge clk_i);
	endtask

	task automatic drain;
		int n;
		n = 0;
		while ((expf.size() != 0 || expr.size() != 0 || active_o !== 1'b0) && n < 4000) begin
			@(negedge clk_i);
			n++;
		end
		chk(9'h000, {8'(expf.size() + expr.size()), active_o});
	endtask

	// Pacing changes at random on the falling edge; receive readiness too, but only while rnd_rdy is set
	always @(negedge clk_i) begin
		dly <= 3'($random(seed));
		rx_ready_i <= rnd_rdy ? 1'($random(seed)) : 1'b1;
	end

	// Scoreboard: each strobe and each receive handover takes the oldest note
	always @(posedge clk_i) begin
		strobe_prev <= host_strobe_n_o;
		if (strobe_prev === 1'b1 && host_strobe_n_o === 1'b0)
			chk(expf.size() ? expf.pop_front() : 'x, {host_ack_n_o, port_data_o});
		if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
			chk({1'b0, expr.size() ? expr.pop_front() : 8'hxx}, {1'b0, rx_data_o});
		cyc++;
		if (cyc == 10000) begin
			bad_count++;
			$display("timeout at %0t", $time);
			results();
		end
	end

	initial begin
		seed = 32'h5f92_022c;
		bad_count = 0;
		num_checks = 0;
		rst_i = 1'b1;
		mode_i = 2'h0;
		tx_data_i = 8'h00;
		tx_cmd_i = 1'b0;
		tx_valid_i = 1'b0;
		tc_i = 1'b0;
		rnd_rdy = 1'b0;
		b = 8'h00;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		// Fill the buffer while the engine is off, then drain in compatibility mode
		for (int i = 0; i < 8; i++) push(1'b0, 8'($random(seed)));
		chk(9'h000, {8'h00, tx_ready_o});
		tx_valid_i = 1'b0;
		mode_i = 2'h1;
		drain();
		chk(9'h000, {8'h00, busy_late_o});
		repeat (100) @(negedge clk_i);
		chk({1'b1, tx_data_i}, {port_data_oe_o, port_data_o});
		$display("compat test done");
		mode_i = 2'h2;
		repeat (4) @(negedge clk_i);
		// Each byte differs from the last so every data change is visible
		for (int i = 0; i < 12; i++)
			push(1'($random(seed)), tx_data_i + 8'h01 + (8'($random(seed)) & 8'h0f));
		tx_valid_i = 1'b0;
		drain();
		$display("ecp forward test done");
		mode_i = 2'h3;
		rnd_rdy = 1'b1;
		repeat (4) @(negedge clk_i);
		for (int i = 0; i < 8; i++) begin
			b = 8'($random(seed));
			expr.push_back(b);
			i_per.send(b);
			@(negedge clk_i);
		end
		tc_i = 1'b1;
		b = 8'($random(seed));
		expr.push_back(b);
		fork
			i_per.send(b);
			begin
				repeat (20) @(negedge clk_i);
				chk(9'h002, {6'h00, port_data_oe_o, stall_o, host_ack_n_o});
				tc_i = 1'b0;
			end
		join
		@(negedge clk_i);
		rnd_rdy = 1'b0;
		drain();
		$display("ecp reverse test done");
		results();
	end
endmodule // tb_top
